//--- rtl/sensor_flag_pkg.sv
// Purpose: constants and types for the sensor flag bank
// Assumes: 16-bit register words at even byte addresses
// Notes: masks follow the live flag word layout
package sensor_flag_pkg;

  // register byte addresses
  localparam logic [7:0] OFS_COMMAND = 8'h22;
  localparam logic [7:0] OFS_TEMP_RESULT = 8'h2E;
  localparam logic [7:0] OFS_PRESS_RESULT = 8'h30;
  localparam logic [7:0] OFS_SYNCED_FLAGS = 8'h32;
  localparam logic [7:0] OFS_EVENT_STATUS = 8'h36;
  localparam logic [7:0] OFS_SERIAL_LOW = 8'h50;
  localparam logic [7:0] OFS_SERIAL_HIGH = 8'h52;
  localparam logic [7:0] ADDR_STEP = 8'h02;

  // bit positions in the flag words
  localparam int BIT_IDLE = 0;
  localparam int BIT_PRESS_NEW = 3;
  localparam int BIT_TEMP_NEW = 4;
  localparam int BIT_SUPPLY_FAULT = 7;
  localparam int BIT_CHECK_FAULT = 8;
  localparam int BIT_SATURATED = 10;
  localparam int BIT_CRC_ERROR = 11;
  localparam int BIT_PRESS_MISSED = 14;
  localparam int BIT_TEMP_MISSED = 15;

  // bits 15,14,11,8,7,4,3
  localparam logic [15:0] EVENT_MASK = 16'hC998;
  // bits 15:5 and 0 mirror the live word
  localparam logic [15:0] MIRROR_MASK = 16'hFFE1;
  localparam logic [15:0] FLAGS_RESET = 16'h0000;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [31:0] SERIAL_RESET = 32'h0000_0000;
  localparam logic [7:0] ADDR_RESET = 8'h00;

  typedef enum logic [1:0] {
    LINK_IDLE = 2'b00,
    LINK_WAIT = 2'b01,
    LINK_DONE = 2'b11
  } link_state_type;

  function automatic logic [15:0] flag_bit(input int pos);
    flag_bit = 16'h0001 << pos;
  endfunction

endpackage

//--- rtl/sensor_status_flag_bank.sv
// Purpose: live flag word, synchronized snapshot and serial words of the sensor
// Assumes: datapath inputs are on sys_clk_in; serial engine inputs on link_clk_in
// Notes: word accesses cross from the link clock by a toggle handshake
`timescale 1ns/1ns

module sensor_status_flag_bank
  import sensor_flag_pkg::*;
(
  input wire logic sys_clk_in, // core clock, 100 MHz
  input wire logic rstn_in, // synchronous reset, active low
  input wire logic ce_in, // clock enable, freezes state when low
  input wire logic temp_update_in, // pulse: new temperature result
  input wire logic [15:0] temp_value_in, // temperature result value
  input wire logic press_update_in, // pulse: new pressure result
  input wire logic [15:0] press_value_in, // pressure result value
  input wire logic idle_in, // level: chip idle
  input wire logic saturated_in, // level: result computation clipped
  input wire logic bridge_supply_fault_in, // pulse: bridge supply failure
  input wire logic bridge_check_fault_in, // pulse: bridge check failure
  input wire logic [31:0] serial_number_in, // unique serial number
  input wire logic link_clk_in, // serial engine clock
  input wire logic link_start_in, // pulse: load word pointer
  input wire logic [7:0] link_addr_in, // start byte address
  input wire logic link_read_in, // pulse: read word at pointer
  input wire logic link_write_in, // pulse: write word at pointer
  input wire logic [15:0] link_wdata_in, // write word
  input wire logic link_crc_error_in, // pulse: checksum mismatch seen
  output logic link_busy_out, // access in flight
  output logic link_done_out, // pulse: access finished
  output logic link_refused_out, // pulse with done: write refused
  output logic [15:0] link_rdata_out, // read word, valid with done
  output logic [15:0] event_status_out, // live flag word
  output logic [15:0] synced_flags_out // synchronized snapshot word
);

  // link domain state
  logic lrst_s1;
  logic lrst_s2;
  logic lce_s1;
  logic lce_s2;
  logic ack_s1;
  logic ack_s2;
  link_state_type state;
  logic [7:0] ptr;
  logic req_tgl;
  logic crc_tgl;
  logic hold_write;
  logic [7:0] hold_addr;
  logic [15:0] hold_wdata;

  // core domain state
  logic req_s1;
  logic req_s2;
  logic crc_s1;
  logic crc_s2;
  logic crc_s3;
  logic ack_tgl;
  logic [15:0] live_flags;
  logic [15:0] synced_flags;
  logic snap_press;
  logic snap_temp;
  logic [15:0] temp_result;
  logic [15:0] press_result;
  logic [31:0] serial_word;
  logic [15:0] rdata_hold;
  logic refused_hold;

  // ---------------- core clock side ----------------

  wire access_go;
  wire acc_read;
  wire acc_write;
  wire crc_event;
  assign access_go = req_s2 != ack_tgl;
  assign acc_read = access_go & ~hold_write;
  assign acc_write = access_go & hold_write;
  assign crc_event = crc_s2 ^ crc_s3;

  wire hit_command;
  wire hit_temp;
  wire hit_press;
  wire hit_synced;
  wire hit_status;
  wire hit_ser_lo;
  wire hit_ser_hi;
  assign hit_command = hold_addr == OFS_COMMAND;
  assign hit_temp = hold_addr == OFS_TEMP_RESULT;
  assign hit_press = hold_addr == OFS_PRESS_RESULT;
  assign hit_synced = hold_addr == OFS_SYNCED_FLAGS;
  assign hit_status = hold_addr == OFS_EVENT_STATUS;
  assign hit_ser_lo = hold_addr == OFS_SERIAL_LOW;
  assign hit_ser_hi = hold_addr == OFS_SERIAL_HIGH;

  wire read_press;
  wire read_temp;
  wire write_open;
  assign read_press = acc_read & hit_press;
  assign read_temp = acc_read & hit_temp;
  // command writes are accepted but act elsewhere
  assign write_open = hit_status | hit_command;

  // write one clears; reserved and status bits masked off
  wire [15:0] clear_mask;
  assign clear_mask = (acc_write & hit_status) ? (hold_wdata & EVENT_MASK)
                                               : FLAGS_RESET;

  wire [15:0] auto_clear;
  assign auto_clear = (read_press ? flag_bit(BIT_PRESS_NEW) : FLAGS_RESET)
                    | (read_temp ? flag_bit(BIT_TEMP_NEW) : FLAGS_RESET);

  // a sample is lost only if nobody reads it in the same cycle
  wire press_missed;
  wire temp_missed;
  assign press_missed = press_update_in & live_flags[BIT_PRESS_NEW] & ~read_press;
  assign temp_missed = temp_update_in & live_flags[BIT_TEMP_NEW] & ~read_temp;

  wire [15:0] set_mask;
  assign set_mask = (press_update_in ? flag_bit(BIT_PRESS_NEW) : FLAGS_RESET)
                  | (temp_update_in ? flag_bit(BIT_TEMP_NEW) : FLAGS_RESET)
                  | (bridge_supply_fault_in ? flag_bit(BIT_SUPPLY_FAULT) : FLAGS_RESET)
                  | (bridge_check_fault_in ? flag_bit(BIT_CHECK_FAULT) : FLAGS_RESET)
                  | (crc_event ? flag_bit(BIT_CRC_ERROR) : FLAGS_RESET)
                  | (press_missed ? flag_bit(BIT_PRESS_MISSED) : FLAGS_RESET)
                  | (temp_missed ? flag_bit(BIT_TEMP_MISSED) : FLAGS_RESET);

  // set applied after clear, so a same-cycle event survives
  wire [15:0] next_events;
  assign next_events = ((live_flags & EVENT_MASK) & ~clear_mask & ~auto_clear) | set_mask;

  wire [15:0] next_levels;
  assign next_levels = (idle_in ? flag_bit(BIT_IDLE) : FLAGS_RESET)
                     | (saturated_in ? flag_bit(BIT_SATURATED) : FLAGS_RESET);

  wire [15:0] next_live;
  assign next_live = next_events | next_levels;

  // snapshot takes the flag as it stood before the read cleared it
  wire next_snap_press;
  wire next_snap_temp;
  assign next_snap_press = read_press ? live_flags[BIT_PRESS_NEW] : snap_press;
  assign next_snap_temp = read_temp ? live_flags[BIT_TEMP_NEW] : snap_temp;

  wire [15:0] next_synced;
  assign next_synced = (next_live & MIRROR_MASK)
                     | (next_snap_press ? flag_bit(BIT_PRESS_NEW) : FLAGS_RESET)
                     | (next_snap_temp ? flag_bit(BIT_TEMP_NEW) : FLAGS_RESET);

  // read data; unmapped addresses return zero
  wire [15:0] next_rdata;
  assign next_rdata = hit_temp ? temp_result
                    : hit_press ? press_result
                    : hit_synced ? synced_flags
                    : hit_status ? live_flags
                    : hit_ser_lo ? serial_word[15:0]
                    : hit_ser_hi ? serial_word[31:16]
                    : WORD_RESET;

  wire next_refused;
  assign next_refused = acc_write & ~write_open;

  // writes answer with zero read data
  wire [15:0] next_rdata_hold;
  assign next_rdata_hold = acc_read ? next_rdata : WORD_RESET;

  // handshake synchroniser; only the second stage is compared
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
    end else if (ce_in) begin
      req_s1 <= req_tgl;
      req_s2 <= req_s1;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      crc_s1 <= 1'b0;
      crc_s2 <= 1'b0;
      crc_s3 <= 1'b0;
    end else if (ce_in) begin
      crc_s1 <= crc_tgl;
      crc_s2 <= crc_s1;
      crc_s3 <= crc_s2;
    end
  end

  // one access served per request, answered in the same cycle
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      ack_tgl <= 1'b0;
      rdata_hold <= WORD_RESET;
      refused_hold <= 1'b0;
    end else if (ce_in && access_go) begin
      ack_tgl <= req_s2;
      rdata_hold <= next_rdata_hold;
      refused_hold <= next_refused;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      live_flags <= FLAGS_RESET;
      synced_flags <= FLAGS_RESET;
    end else if (ce_in) begin
      live_flags <= next_live;
      synced_flags <= next_synced;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      snap_press <= 1'b0;
      snap_temp <= 1'b0;
    end else if (ce_in) begin
      snap_press <= next_snap_press;
      snap_temp <= next_snap_temp;
    end
  end

  // results: unread until the first update after reset
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      temp_result <= WORD_RESET;
      press_result <= WORD_RESET;
    end else if (ce_in) begin
      if (temp_update_in) begin
        temp_result <= temp_value_in;
      end
      if (press_update_in) begin
        press_result <= press_value_in;
      end
    end
  end

  // serial number is static on the core clock, so one stage is enough
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      serial_word <= SERIAL_RESET;
    end else if (ce_in) begin
      serial_word <= serial_number_in;
    end
  end

  assign event_status_out = live_flags;
  assign synced_flags_out = synced_flags;

  // ---------------- link clock side ----------------

  // link clock may stop between accesses; synchronisers then keep their last value
  // reset and enable brought into the link domain
  always_ff @(posedge link_clk_in) begin
    lrst_s1 <= rstn_in;
    lrst_s2 <= lrst_s1;
    lce_s1 <= ce_in;
    lce_s2 <= lce_s1;
  end

  always_ff @(posedge link_clk_in) begin
    if (!lrst_s2) begin
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
    end else if (lce_s2) begin
      ack_s1 <= ack_tgl;
      ack_s2 <= ack_s1;
    end
  end

  wire link_req;
  wire [7:0] addr_used;
  wire [7:0] next_ptr;
  wire ack_back;
  assign link_req = link_read_in | link_write_in;
  assign addr_used = link_start_in ? link_addr_in : ptr;
  // wraps past the top of the map, as the pointer is only a byte wide
  assign next_ptr = addr_used + ADDR_STEP;
  assign ack_back = ack_s2 == req_tgl;

  // hold_* stay still until the answer comes back, so they cross safely
  always_ff @(posedge link_clk_in) begin
    if (!lrst_s2) begin
      state <= LINK_IDLE;
      ptr <= ADDR_RESET;
      req_tgl <= 1'b0;
      hold_write <= 1'b0;
      hold_addr <= ADDR_RESET;
      hold_wdata <= WORD_RESET;
    end else if (lce_s2) begin
      case (state)
        LINK_IDLE: begin
          if (link_req) begin
            hold_write <= link_write_in;
            hold_addr <= addr_used;
            hold_wdata <= link_wdata_in;
            req_tgl <= ~req_tgl;
            ptr <= next_ptr;
            state <= LINK_WAIT;
          end else if (link_start_in) begin
            ptr <= link_addr_in;
          end
        end
        LINK_WAIT: begin
          if (ack_back) begin
            state <= LINK_DONE;
          end
        end
        LINK_DONE: begin
          state <= LINK_IDLE;
        end
        default: begin
          state <= LINK_IDLE;
        end
      endcase
    end
  end

  // answer side of the link; requests while busy are dropped
  // a request level still held in the cycle after done is taken a second time
  always_ff @(posedge link_clk_in) begin
    if (!lrst_s2) begin
      link_busy_out <= 1'b0;
      link_done_out <= 1'b0;
      link_refused_out <= 1'b0;
      link_rdata_out <= WORD_RESET;
    end else if (lce_s2) begin
      link_done_out <= 1'b0;
      link_refused_out <= 1'b0;
      if (state == LINK_IDLE && link_req) begin
        link_busy_out <= 1'b1;
      end else if (state == LINK_WAIT && ack_back) begin
        link_busy_out <= 1'b0;
        link_done_out <= 1'b1;
        link_refused_out <= refused_hold;
        link_rdata_out <= rdata_hold;
      end
    end
  end

  // checksum errors reach the core as a toggle
  always_ff @(posedge link_clk_in) begin
    if (!lrst_s2) begin
      crc_tgl <= 1'b0;
    end else if (lce_s2 && link_crc_error_in) begin
      crc_tgl <= ~crc_tgl;
    end
  end

endmodule // sensor_status_flag_bank

//--- verification/host_link_model.sv
// Purpose: host master model driving the bank's link access port
// Assumes: link clock gated here, running only while the access, crc_pulse or clocks task runs
// Notes: released address and data lines show inverted values so stale data is caught
`timescale 1ns/1ns
module host_link_model (
  input wire logic free_clk_in, // free-running link clock source
  input wire logic link_done_in, // access finished
  input wire logic link_refused_in, // write refused
  input wire logic [15:0] link_rdata_in, // read word
  output logic link_clk_out, // gated link clock
  output logic link_start_out = 1'b0, // load pointer
  output logic [7:0] link_addr_out = 8'h00, // start address
  output logic link_read_out = 1'b0, // read request
  output logic link_write_out = 1'b0, // write request
  output logic [15:0] link_wdata_out = 16'h0000, // write word
  output logic link_crc_out = 1'b0 // checksum mismatch pulse
);
  logic run = 1'b0;
  // gate changes only while the source is low, so no glitch
  assign link_clk_out = free_clk_in & run;
  task automatic clocks(input int n);
    @(negedge free_clk_in);
    run = 1'b1;
    repeat (n) @(negedge free_clk_in);
    run = 1'b0;
  endtask
  task automatic crc_pulse();
    @(negedge free_clk_in);
    run = 1'b1;
    link_crc_out = 1'b1;
    @(negedge free_clk_in);
    link_crc_out = 1'b0;
    repeat (3) @(negedge free_clk_in);
    run = 1'b0;
  endtask
  // request held until done; results taken in the done cycle
  task automatic access(input logic s, input logic [7:0] a, input logic wr,
      input logic [15:0] wd, output logic [15:0] rd, output logic rf);
    int n;
    n = 0;
    @(negedge free_clk_in);
    run = 1'b1;
    link_start_out = s;
    link_addr_out = a;
    link_read_out = !wr;
    link_write_out = wr;
    link_wdata_out = wd;
    while (link_done_in !== 1'b1 && n < 40) begin
      @(negedge free_clk_in);
      n++;
    end
    rd = (n < 40) ? link_rdata_in : 16'hxxxx;
    rf = (n < 40) ? link_refused_in : 1'bx;
    link_start_out = 1'b0;
    link_addr_out = ~a;
    link_read_out = 1'b0;
    link_write_out = 1'b0;
    link_wdata_out = ~wd;
    @(negedge free_clk_in);
    run = 1'b0;
  endtask
endmodule // host_link_model

//--- verification/sensor_flag_bank_asserts.sv
// Purpose: concurrent checks on the sensor flag bank ports
// Assumes: ce_in high in normal use; link clock may stop when idle
// Notes: bound to the bank by the statement after the module
`timescale 1ns/1ns
module sensor_flag_bank_asserts
  import sensor_flag_pkg::*;
(
  input wire logic sys_clk_in, // core clock
  input wire logic rstn_in, // synchronous reset, active low
  input wire logic ce_in, // clock enable
  input wire logic temp_update_in, // new temperature pulse
  input wire logic idle_in, // chip idle level
  input wire logic saturated_in, // clipped computation level
  input wire logic bridge_supply_fault_in, // supply fault pulse
  input wire logic link_clk_in, // link clock
  input wire logic link_busy_out, // access in flight
  input wire logic link_done_out, // access finished
  input wire logic link_refused_out, // write refused
  input wire logic [15:0] event_status_out, // live flag word
  input wire logic [15:0] synced_flags_out // snapshot word
);
  sequence s_temp_overrun;
    ce_in && temp_update_in && event_status_out[BIT_TEMP_NEW];
  endsequence
  property p_mirror;
    @(posedge sys_clk_in) disable iff (!rstn_in)
    (synced_flags_out & MIRROR_MASK) == (event_status_out & MIRROR_MASK);
  endproperty
  a_mirror: assert property (p_mirror) else $error("snapshot mirror bits differ");
  property p_reserved;
    @(posedge sys_clk_in) disable iff (!rstn_in)
    ((event_status_out | synced_flags_out) & 16'h3266) == 16'h0000;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit set");
  property p_idle;
    @(posedge sys_clk_in) disable iff (!rstn_in)
    ce_in |=> event_status_out[BIT_IDLE] == $past(idle_in);
  endproperty
  a_idle: assert property (p_idle) else $error("idle bit wrong");
  property p_sat;
    @(posedge sys_clk_in) disable iff (!rstn_in)
    ce_in |=> event_status_out[BIT_SATURATED] == $past(saturated_in);
  endproperty
  a_sat: assert property (p_sat) else $error("clipped bit wrong");
  property p_supply;
    @(posedge sys_clk_in) disable iff (!rstn_in)
    ce_in && bridge_supply_fault_in |=> event_status_out[BIT_SUPPLY_FAULT];
  endproperty
  a_supply: assert property (p_supply) else $error("supply fault not set");
  property p_temp_set;
    @(posedge sys_clk_in) disable iff (!rstn_in)
    ce_in && temp_update_in |=> event_status_out[BIT_TEMP_NEW];
  endproperty
  a_temp_set: assert property (p_temp_set) else $error("temp new not set");
  property p_temp_miss;
    @(posedge sys_clk_in) disable iff (!rstn_in)
    s_temp_overrun |=> event_status_out[BIT_TEMP_MISSED];
  endproperty
  a_temp_miss: assert property (p_temp_miss) else $error("temp overrun not set");
  // the supply fault bit only drops while a host access is in flight
  property p_sticky;
    @(posedge sys_clk_in) disable iff (!rstn_in)
    $fell(event_status_out[BIT_SUPPLY_FAULT]) |-> $past(link_busy_out);
  endproperty
  a_sticky: assert property (p_sticky) else $error("event dropped alone");
  property p_refused;
    @(posedge link_clk_in) disable iff (!rstn_in)
    link_refused_out |-> link_done_out ##1 !link_done_out;
  endproperty
  a_refused: assert property (p_refused) else $error("refused outside done");
  property p_done_idle;
    @(posedge link_clk_in) disable iff (!rstn_in)
    link_done_out |-> !link_busy_out;
  endproperty
  a_done_idle: assert property (p_done_idle) else $error("busy during done");
endmodule // sensor_flag_bank_asserts

bind sensor_status_flag_bank sensor_flag_bank_asserts checker_i (.*);

//--- verification/sensor_status_flag_bank_test.sv
// Purpose: self-checking bench for the sensor flag bank
// Assumes: sys inputs change at falling sys edges, link at falling link edges
// Notes: reset spans several link cycles so the link side sees it
`timescale 1ns/1ns
module sensor_status_flag_bank_test;
  import sensor_flag_pkg::*;
  logic sys_clk_in = 1'b0, rstn_in = 1'b0, ce_in = 1'b1, free_clk = 1'b0;
  logic temp_update_in = 1'b0, press_update_in = 1'b0, idle_in = 1'b0, saturated_in = 1'b0;
  logic bridge_supply_fault_in = 1'b0, bridge_check_fault_in = 1'b0;
  logic [15:0] temp_value_in = 16'h0C3A, press_value_in = 16'h8001;
  logic [31:0] serial_number_in = 32'h1234_5678;
  wire logic link_clk_in, link_start_in, link_read_in, link_write_in, link_crc_error_in;
  wire logic link_busy_out, link_done_out, link_refused_out;
  wire logic [7:0] link_addr_in;
  wire logic [15:0] link_wdata_in, link_rdata_out, event_status_out, synced_flags_out;
  int fail_count = 0, compares = 0, cycles = 0;
  logic [15:0] rdata;
  logic refused;
  always #5 sys_clk_in = ~sys_clk_in;
  always #32 free_clk = ~free_clk;
  host_link_model host (.free_clk_in(free_clk), .link_done_in(link_done_out),
    .link_refused_in(link_refused_out), .link_rdata_in(link_rdata_out),
    .link_clk_out(link_clk_in), .link_start_out(link_start_in), .link_addr_out(link_addr_in),
    .link_read_out(link_read_in), .link_write_out(link_write_in),
    .link_wdata_out(link_wdata_in), .link_crc_out(link_crc_error_in));
  sensor_status_flag_bank dut (.*);
  task automatic finish_test();
    if (fail_count == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic pulse(ref logic s);
    @(negedge sys_clk_in);
    s = 1'b1;
    @(negedge sys_clk_in);
    s = 1'b0;
  endtask
  task automatic write_word(input logic [7:0] a, input logic [15:0] d, input logic e);
    host.access(1'b1, a, 1'b1, d, rdata, refused);
    chk({15'h0000, refused}, {15'h0000, e});
  endtask
  task automatic read_word(input logic s, input logic [7:0] a, input logic [15:0] e);
    host.access(s, a, 1'b0, 16'h0000, rdata, refused);
    chk(rdata, e);
  endtask
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 8000) begin
      fail_count++;
      finish_test();
    end
  end
  initial begin
    fork
      host.clocks(10);
      begin
        repeat (40) @(negedge sys_clk_in);
        rstn_in = 1'b1;
      end
    join
    chk(event_status_out, 16'h0000);
    chk(synced_flags_out, 16'h0000);
    @(negedge sys_clk_in);
    idle_in = 1'b1;
    saturated_in = 1'b1;
    pulse(temp_update_in);
    pulse(press_update_in);
    pulse(bridge_supply_fault_in);
    pulse(bridge_check_fault_in);
    pulse(temp_update_in);
    pulse(press_update_in);
    host.crc_pulse();
    repeat (10) @(negedge sys_clk_in);
    chk(event_status_out, 16'hCD99);
    chk(synced_flags_out, 16'hCD81);
    write_word(OFS_SYNCED_FLAGS, 16'hFFFF, 1'b1);
    write_word(OFS_SERIAL_LOW, 16'hFFFF, 1'b1);
    write_word(OFS_COMMAND, 16'h0000, 1'b0);
    chk(event_status_out, 16'hCD99);
    read_word(1'b1, OFS_TEMP_RESULT, 16'h0C3A);
    read_word(1'b0, 8'h00, 16'h8001);
    read_word(1'b0, 8'h00, 16'hCD99);
    chk(event_status_out, 16'hCD81);
    write_word(OFS_EVENT_STATUS, 16'h0080, 1'b0);
    chk(event_status_out, 16'hCD01);
    write_word(OFS_EVENT_STATUS, 16'hFFFF, 1'b0);
    chk(event_status_out, 16'h0401);
    @(negedge sys_clk_in);
    idle_in = 1'b0;
    saturated_in = 1'b0;
    repeat (3) @(negedge sys_clk_in);
    chk(event_status_out, 16'h0000);
    ce_in = 1'b0;
    pulse(bridge_check_fault_in);
    chk(event_status_out, 16'h0000);
    ce_in = 1'b1;
    read_word(1'b1, OFS_TEMP_RESULT, 16'h0C3A);
    read_word(1'b0, 8'h00, 16'h8001);
    read_word(1'b0, 8'h00, 16'h0000);
    read_word(1'b1, OFS_SERIAL_LOW, 16'h5678);
    read_word(1'b0, 8'h00, 16'h1234);
    read_word(1'b1, 8'h40, 16'h0000);
    finish_test();
  end
endmodule // sensor_status_flag_bank_test
